// [logic/dcf_capability_regs.sv]
// APB slave that presents the read-only capability word plus its control and status words.
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/10ps
module dcf_capability_regs (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst,
	// APB request.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	// APB answer.
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);

	dcf_pkg::dcf_apb_req_t req;
	dcf_pkg::dcf_sel_t     sel;
	logic [31:0]           cap_word;
	logic                  setup;
	logic                  access;
	logic [31:0]           rd_mux;

	logic        next_pready;
	logic        next_pslverr;
	logic [31:0] next_prdata;

	logic        err_on_write;
	logic        next_err_on_write;
	logic [15:0] ignored_writes;
	logic [15:0] next_ignored_writes;

	assign req.psel    = psel;
	assign req.penable = penable;
	assign req.pwrite  = pwrite;
	assign req.paddr   = paddr;
	assign req.pwdata  = pwdata;

	dcf_cap_word u_cap_word (
		.cap_word (cap_word)
	);

	dcf_addr_decode u_addr_decode (
		.paddr (req.paddr),
		.sel   (sel)
	);

	assign setup  = req.psel && !req.penable;
	assign access = req.psel && req.penable && pready;

	always_comb begin
		unique case (sel)
			dcf_pkg::DCF_SEL_CAP:  rd_mux = cap_word;
			dcf_pkg::DCF_SEL_CTRL: rd_mux = {31'h0000_0000, err_on_write};
			dcf_pkg::DCF_SEL_STAT: rd_mux = {16'h0000, ignored_writes};
			dcf_pkg::DCF_SEL_NONE: rd_mux = 32'h0000_0000;
		endcase
	end

	// The answer is prepared in the setup cycle so that pready and prdata come from flops.
	always_comb begin
		next_pready  = setup;
		next_prdata  = prdata;
		next_pslverr = 1'b0;
		if (setup) begin
			next_prdata = req.pwrite ? 32'h0000_0000 : rd_mux;
			if (sel == dcf_pkg::DCF_SEL_NONE) begin
				next_pslverr = 1'b1;
			end else if (req.pwrite && sel == dcf_pkg::DCF_SEL_CAP) begin
				next_pslverr = err_on_write;
			end else if (req.pwrite && sel == dcf_pkg::DCF_SEL_STAT) begin
				next_pslverr = err_on_write;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= next_pready;
			pslverr <= next_pslverr;
			prdata  <= next_prdata;
		end
	end

	// A write to the capability word changes nothing but the count of ignored writes.
	always_comb begin
		next_err_on_write   = err_on_write;
		next_ignored_writes = ignored_writes;
		if (access && req.pwrite) begin
			unique case (sel)
				dcf_pkg::DCF_SEL_CTRL: begin
					next_err_on_write = req.pwdata[dcf_pkg::CTRL_ERR_ON_WRITE_BIT];
				end
				dcf_pkg::DCF_SEL_CAP: begin
					// The count saturates so that a long run of stray writes cannot wrap to zero.
					if (ignored_writes != dcf_pkg::STAT_MAX) begin
						next_ignored_writes = ignored_writes + 16'h0001;
					end
				end
				dcf_pkg::DCF_SEL_STAT: begin
					next_ignored_writes = dcf_pkg::STAT_RESET;
				end
				dcf_pkg::DCF_SEL_NONE: begin
					next_ignored_writes = ignored_writes;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			err_on_write   <= dcf_pkg::CTRL_RESET;
			ignored_writes <= dcf_pkg::STAT_RESET;
		end else begin
			err_on_write   <= next_err_on_write;
			ignored_writes <= next_ignored_writes;
		end
	end

	// Helper terms for the checks below.
	logic rd_cap_acc;
	logic wr_cap_acc;
	logic rd_cap_setup;
	assign rd_cap_acc   = access && !req.pwrite && sel == dcf_pkg::DCF_SEL_CAP;
	assign wr_cap_acc   = access && req.pwrite && sel == dcf_pkg::DCF_SEL_CAP;
	assign rd_cap_setup = setup && !req.pwrite && sel == dcf_pkg::DCF_SEL_CAP;

	a_min_divider: assert property (
		@(posedge clk) disable iff (rst)
		rd_cap_acc |-> prdata[15:12] == 4'h3
	) else $error("minimum divider field is not 0x3");

	a_rate_field: assert property (
		@(posedge clk) disable iff (rst)
		rd_cap_setup |=> pready && prdata[9:8] == 2'h2
	) else $error("rate field is not 0x2 one cycle after setup");

	a_rate_readonly: assert property (
		@(posedge clk) disable iff (rst)
		wr_cap_acc ##1 rd_cap_setup |=> prdata[9:8] == 2'h2 && !pslverr
	) else $error("rate field changed after a write");

	a_mpu_bit: assert property (
		@(posedge clk) disable iff (rst)
		rd_cap_acc |-> prdata[7] && !pslverr
	) else $error("protection unit bit is not set");

	a_hib_bit: assert property (
		@(posedge clk) disable iff (rst)
		rd_cap_setup ##1 rd_cap_acc |-> prdata[6] == 1'b1
	) else $error("hibernate bit is not set");

	a_temp_bit: assert property (
		@(posedge clk) disable iff (rst)
		rd_cap_acc |-> prdata[5] == 1'b1 && pready
	) else $error("temperature sensor bit is not set");

	a_pll_bit: assert property (
		@(posedge clk) disable iff (rst)
		rd_cap_setup |-> ##1 prdata[4]
	) else $error("pll bit is not set");

	a_wdog_bit: assert property (
		@(posedge clk) disable iff (rst)
		rd_cap_acc |-> prdata[3]
	) else $error("watchdog bit is not set");

	a_trace_bit: assert property (
		@(posedge clk) disable iff (rst)
		rd_cap_acc |-> prdata[2] == 1'b1
	) else $error("trace port bit is not set");

	a_wire_dbg_bit: assert property (
		@(posedge clk) disable iff (rst)
		rd_cap_acc |-> prdata[1] == 1'b1
	) else $error("serial debug bit is not set");

	a_scan_dbg_bit: assert property (
		@(posedge clk) disable iff (rst)
		rd_cap_acc |-> prdata[0] == 1'b1
	) else $error("boundary-scan bit is not set");

	a_low_word: assert property (
		@(posedge clk) disable iff (rst)
		rd_cap_acc |-> prdata == 32'h0000_32ff
	) else $error("capability word is not 0x000032ff");

	a_write_ignored: assert property (
		@(posedge clk) disable iff (rst)
		wr_cap_acc && ignored_writes != 16'hffff |=>
			ignored_writes == $past(ignored_writes) + 16'h0001 && cap_word == 32'h0000_32ff
	) else $error("write to capability word was not ignored and counted");

	a_write_error: assert property (
		@(posedge clk) disable iff (rst)
		setup && req.pwrite && sel == dcf_pkg::DCF_SEL_CAP |=> pslverr == $past(err_on_write)
	) else $error("error answer does not follow the control bit");

	a_stat_write_err: assert property (
		@(posedge clk) disable iff (rst)
		setup && req.pwrite && sel == dcf_pkg::DCF_SEL_STAT |=> pslverr == $past(err_on_write)
	) else $error("status write error answer does not follow the control bit");

	a_unmapped_err: assert property (
		@(posedge clk) disable iff (rst)
		setup && sel == dcf_pkg::DCF_SEL_NONE |=> pready && pslverr && prdata == 32'h0000_0000
	) else $error("unmapped access did not answer with an error and zero data");

	a_ready_pulse: assert property (
		@(posedge clk) disable iff (rst)
		pready |=> !pready
	) else $error("pready stood for more than one cycle");

endmodule : dcf_capability_regs

// [logic/dcf_pkg.sv]
// Package with the register map, field layout and carrier types of the capability block.
// What this block does
// - Bits 15:12 always read 0x3, the smallest clock divider, meaning a 50 MHz core clock.
// - Bits 9:8 always read 0x2, meaning a top converter rate of 500K samples per second.
// - The converter rate field is read-only and holds its encoded constant from reset on.
// - Bit 7 reads 1 because the memory protection unit is built in.
// - Bit 6 reads 1 because the hibernation module is built in.
// - Bit 5 reads 1 because the on-chip temperature sensor is built in.
// - Bit 4 reads 1 because the on-chip phase-locked loop is built in.
// - Bit 3 reads 1 because the watchdog timer is built in.
// - Bit 2 reads 1 because the serial trace output port is built in.
// - Bit 1 reads 1 because the two-wire serial debug port is built in.
// - Bit 0 reads 1 because the boundary-scan debug interface is built in.
package dcf_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	localparam logic [11:0] CAP_ONE_OFFSET = 12'h010;
	localparam logic [11:0] CTRL_OFFSET    = 12'h020;
	localparam logic [11:0] STAT_OFFSET    = 12'h024;

	localparam logic [3:0] MIN_CLOCK_DIVIDER_VAL = 4'h3;
	localparam logic [1:0] MAX_SAMPLE_RATE_VAL   = 2'h2;
	localparam logic [1:0] RESERVED_VAL          = 2'h0;
	localparam logic       PRESENT               = 1'b1;

	localparam int CTRL_ERR_ON_WRITE_BIT = 0;
	localparam logic        CTRL_RESET   = 1'b0;
	localparam logic [15:0] STAT_RESET   = 16'h0000;
	localparam logic [15:0] STAT_MAX     = 16'hffff;

	typedef enum logic [1:0] {
		DCF_SEL_CAP,
		DCF_SEL_CTRL,
		DCF_SEL_STAT,
		DCF_SEL_NONE
	} dcf_sel_t;

	typedef struct packed {
		logic [3:0] min_clock_divider;
		logic [1:0] reserved;
		logic [1:0] max_sample_rate;
		logic       protection_unit_present;
		logic       hibernate_present;
		logic       temp_sensor_present;
		logic       pll_present;
		logic       watchdog_present;
		logic       trace_out_present;
		logic       wire_debug_present;
		logic       scan_debug_present;
	} dcf_cap_low_t;

	localparam dcf_cap_low_t CAP_LOW_VAL = '{
		min_clock_divider:       MIN_CLOCK_DIVIDER_VAL,
		reserved:                RESERVED_VAL,
		max_sample_rate:         MAX_SAMPLE_RATE_VAL,
		protection_unit_present: PRESENT,
		hibernate_present:       PRESENT,
		temp_sensor_present:     PRESENT,
		pll_present:             PRESENT,
		watchdog_present:        PRESENT,
		trace_out_present:       PRESENT,
		wire_debug_present:      PRESENT,
		scan_debug_present:      PRESENT
	};

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} dcf_apb_req_t;

endpackage : dcf_pkg

// [logic/dcf_cap_word.sv]
// Builds the constant capability word from its packed fields.
`timescale 1ns/10ps
module dcf_cap_word (
	// Capability word.
	output wire logic [31:0] cap_word
);

	dcf_pkg::dcf_cap_low_t fields;

	// Every field is a tie-off, so no write path can ever reach them.
	assign fields   = dcf_pkg::CAP_LOW_VAL;
	// Upper fields belong to other logic and read as zero here.
	assign cap_word = {16'h0000, fields};

endmodule : dcf_cap_word

// [logic/dcf_addr_decode.sv]
// Decodes an APB address into a register select.
`timescale 1ns/10ps
module dcf_addr_decode (
	// Address in.
	input  wire logic [11:0]      paddr,
	// Register select out.
	output dcf_pkg::dcf_sel_t     sel
);

	function automatic dcf_pkg::dcf_sel_t decode(input logic [11:0] addr);
		unique case (addr)
			dcf_pkg::CAP_ONE_OFFSET: decode = dcf_pkg::DCF_SEL_CAP;
			dcf_pkg::CTRL_OFFSET:    decode = dcf_pkg::DCF_SEL_CTRL;
			dcf_pkg::STAT_OFFSET:    decode = dcf_pkg::DCF_SEL_STAT;
			default:                 decode = dcf_pkg::DCF_SEL_NONE;
		endcase
	endfunction : decode

	assign sel = decode(paddr);

endmodule : dcf_addr_decode

// [testbench/tb.sv]
// Self-checking testbench for the capability register block.
`timescale 1ns/10ps
module tb;
	// Clock and reset.
	logic        clk;
	logic        rst;
	// APB request and answer.
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	// Bench state.
	int          fails;
	int          num_checks;
	logic [31:0] rd;
	logic [31:0] keep;
	logic        err;

	dcf_capability_regs u_dut (
		.clk     (clk),
		.rst     (rst),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : chk

	// Entered just after a rising edge with penable low. The request stands until the edge at
	// which pready is sampled high; the answer is taken at that edge, then penable alone drops and psel stays high until idle.
	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
		int n;
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= addr;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			fails++;
			$display("mismatch at %0t: no pready", $time);
			end_sim;
		end
		rd      = prdata;
		err     = pslverr;
		penable <= 1'b0;
	endtask : apb

	task automatic idle;
		psel <= 1'b0;
		@(posedge clk);
	endtask : idle

	task automatic t_fields;
		apb(1'b0, 12'h010, 32'h0);
		idle;
		chk(rd & 32'h0000f000, 32'h00003000, "min divider");
		chk(rd & 32'h00000300, 32'h00000200, "max rate");
		chk(rd & 32'h00000080, 32'h00000080, "protection unit");
		chk(rd & 32'h00000040, 32'h00000040, "hibernate");
		chk(rd & 32'h00000020, 32'h00000020, "temp sensor");
		chk(rd & 32'h00000010, 32'h00000010, "pll");
		chk(rd & 32'h00000008, 32'h00000008, "watchdog");
		chk(rd & 32'h00000004, 32'h00000004, "trace out");
		chk(rd & 32'h00000002, 32'h00000002, "wire debug");
		chk(rd & 32'h00000001, 32'h00000001, "scan debug");
		chk({31'h0, err}, 32'h0, "read error flag");
		$display("test fields done");
	endtask : t_fields

	task automatic t_ignored;
		apb(1'b1, 12'h024, 32'h0);
		apb(1'b1, 12'h010, 32'hffffcd00);
		chk({31'h0, err}, 32'h0, "quiet write error flag");
		apb(1'b0, 12'h010, 32'h0);
		keep = rd;
		chk(rd, 32'h000032ff, "word after write");
		apb(1'b1, 12'h010, keep);
		apb(1'b0, 12'h010, 32'h0);
		chk(rd & 32'h00000c00, keep & 32'h00000c00, "reserved carried");
		chk(rd & 32'h00000300, 32'h00000200, "rate after writes");
		apb(1'b0, 12'h024, 32'h0);
		chk(rd & 32'h0000ffff, 32'h00000002, "ignored count");
		apb(1'b1, 12'h024, 32'h0);
		apb(1'b0, 12'h024, 32'h0);
		idle;
		chk(rd & 32'h0000ffff, 32'h0, "count cleared");
		$display("test ignored writes done");
	endtask : t_ignored

	task automatic t_err_write;
		apb(1'b1, 12'h020, 32'h1);
		apb(1'b0, 12'h020, 32'h0);
		chk(rd & 32'h1, 32'h1, "control bit");
		apb(1'b1, 12'h010, 32'h0);
		chk({31'h0, err}, 32'h1, "error on write");
		apb(1'b0, 12'h010, 32'h0);
		chk(rd, 32'h000032ff, "word after refused write");
		apb(1'b1, 12'h024, 32'h0);
		chk({31'h0, err}, 32'h1, "error on status write");
		apb(1'b0, 12'h024, 32'h0);
		chk(rd & 32'h0000ffff, 32'h0, "status cleared despite error");
		apb(1'b1, 12'h020, 32'h0);
		idle;
		$display("test error on write done");
	endtask : t_err_write

	task automatic t_unmapped;
		apb(1'b0, 12'h0fc, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped read error");
		chk(rd, 32'h0, "unmapped read data");
		apb(1'b1, 12'h100, 32'hffffffff);
		chk({31'h0, err}, 32'h1, "unmapped write error");
		apb(1'b0, 12'h010, 32'h0);
		idle;
		chk(rd, 32'h000032ff, "word after unmapped");
		$display("test unmapped done");
	endtask : t_unmapped

	task automatic t_reset;
		apb(1'b1, 12'h020, 32'h1);
		apb(1'b1, 12'h010, 32'h0);
		idle;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(1'b0, 12'h020, 32'h0);
		chk(rd & 32'h1, 32'h0, "control after reset");
		apb(1'b0, 12'h024, 32'h0);
		chk(rd & 32'h0000ffff, 32'h0, "count after reset");
		apb(1'b0, 12'h010, 32'h0);
		idle;
		chk(rd, 32'h000032ff, "word after reset");
		$display("test mid reset done");
	endtask : t_reset

	initial begin
		rst        = 1'b1;
		psel       = 1'b0;
		penable    = 1'b0;
		pwrite     = 1'b0;
		paddr      = 12'h000;
		pwdata     = 32'h0;
		fails      = 0;
		num_checks = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_fields;
		t_ignored;
		t_err_write;
		t_unmapped;
		t_reset;
		end_sim;
	end
endmodule : tb
